//--- src/memctl_pkg.sv
package memctl_pkg;

    // register byte offsets
    localparam logic [4:0] OFS_BANK0_CONFIG = 5'h00;
    localparam logic [4:0] OFS_BANK1_CONFIG = 5'h04;
    localparam logic [4:0] OFS_RESERVED_A = 5'h08;
    localparam logic [4:0] OFS_RESERVED_B = 5'h0c;
    localparam logic [4:0] OFS_BANK1_START = 5'h10;

    // config field positions
    localparam int LEN_LSB = 8;
    localparam int LEN_MSB = 14;
    localparam int READY_EXT_BIT = 7;
    localparam int SYNC_OPT_BIT = 6;
    localparam int BANK_ON_BIT = 5;
    localparam int WAIT_LSB = 2;
    localparam int WAIT_MSB = 4;
    localparam int START_MSB = 11;
    localparam int START_ADDR_LSB = 11;
    localparam int LEN_ADDR_LSB = 16;

    // reset values
    localparam logic [15:0] BANK0_CONFIG_RESET = 16'h7f3d;
    localparam logic [15:0] BANK1_CONFIG_RESET = 16'h0001;
    localparam logic [15:0] RESERVED_RESET = 16'h0001;
    localparam logic [15:0] BANK1_START_RESET = 16'h0000;

    // writable bits of each register
    localparam logic [15:0] CONFIG_WMASK = 16'h7ffc;
    localparam logic [15:0] START_WMASK = 16'h0fff;

    // base cycle length beyond the wait states
    localparam logic [3:0] BASE_CYCLES = 4'h2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [6:0] len;
        logic ready_extension_on;
        logic ready_sync_option;
        logic bank_on;
        logic [2:0] waits;
    } bank_cfg_type;

    typedef struct packed {
        logic [22:0] addr;
        logic write;
        logic [15:0] wdata;
    } mem_req_type;

endpackage : memctl_pkg

//--- src/ready_sampler.sv
`timescale 1ns/1ns
// ready input path: every pin passes two flops; the sync option adds a second pair
module ready_sampler (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin and option
    input wire logic ready_pin,
    input wire logic sync_on,
    // sampled level
    output logic ready_seen
);
    logic ready_sync_first_reg, ready_sync_second_reg;
    logic extra_first_reg, extra_second_reg;
    logic extra_first_next, extra_second_next;

    always_comb begin
        extra_first_next = ready_sync_second_reg;
        extra_second_next = extra_first_reg;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_sync_first_reg <= 1'b0;
            ready_sync_second_reg <= 1'b0;
            extra_first_reg <= 1'b0;
            extra_second_reg <= 1'b0;
        end else begin
            ready_sync_first_reg <= ready_pin;
            ready_sync_second_reg <= ready_sync_first_reg;
            extra_first_reg <= extra_first_next;
            extra_second_reg <= extra_second_next;
        end
    end

    assign ready_seen = sync_on ? extra_second_reg : ready_sync_second_reg; // RULE10
endmodule : ready_sampler

//--- src/external_memory_bank_controller.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
// How it works
// RULE1: bank 1 start = base field in address bits 22..11, low bits zero.
// RULE2: software writes zero to base register bits 15..12.
// RULE3: unreachable bank 1: software writes base register only as zero.
// RULE4: bank 0 config resets to length 7f, enabled, seven waits, options off.
// RULE5: all other registers reset to one or zero.
// RULE6: software writes one to config bit 0 and reserved slots.
// RULE7: ready extension: check ready after waits, add one wait while low.
// RULE8: no ready extension: cycle ends after exactly programmed waits.
// RULE9: enable ready extension only for variable access time memories.
// RULE10: sync option resamples ready through extra flops, adding wait states.
// RULE11: unsynchronised ready needs at least four wait states.
// RULE12: at most one select active; bank 0 wins on overlap.
// RULE13: software keeps bank regions from overlapping.
// RULE14: select lasts wait count plus two clocks; waits 0..7.
// RULE15: length field sets region in 64 KB steps, 64 KB to 8 MB.
// RULE16: select only for enabled bank; disabled bank makes no cycle.
// RULE17: select when start <= address < start + length.
// RULE18: bank 0 starts at address zero.
module external_memory_bank_controller (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // axi4-lite write address
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // axi4-lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read address
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    // axi4-lite read data
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // memory request from the system side
    input wire memctl_pkg::mem_req_type MEM_REQ,
    input wire logic MEM_REQ_VALID,
    output logic MEM_REQ_READY,
    output logic [15:0] MEM_RDATA,
    output logic MEM_DONE,
    output logic MEM_MISS,
    // external memory port
    output logic [22:0] EXT_ADDR,
    output logic [15:0] EXT_DATA_OUT,
    input wire logic [15:0] EXT_DATA_IN,
    output logic EXT_DATA_OE_B,
    output logic EXT_WRITE_B,
    output logic EXT_READ_B,
    output logic SELECT_LINE_PRIMARY_B,
    output logic SELECT_LINE_SECONDARY_B,
    input wire logic EXT_READY,
    // access state for observation
    output logic ACCESS_BUSY
);
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_READY = 3'b100}
        mem_state_type;
    // register file; the reserved slots are constants, not flops
    logic [15:0] bank0_config_reg, bank0_config_next;
    logic [15:0] bank1_config_reg, bank1_config_next;
    logic [15:0] bank1_start_reg, bank1_start_next;
    // bus slave state
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [4:0] aw_addr_reg, aw_addr_next;
    logic aw_bad_reg, aw_bad_next;
    logic [15:0] w_data_reg, w_data_next;
    logic [1:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    // memory access state
    mem_state_type state_reg, state_next;
    logic [3:0] count_reg, count_next;
    logic sel0_reg, sel0_next;
    logic sel1_reg, sel1_next;
    logic ext_on_reg, ext_on_next;
    logic [22:0] addr_reg, addr_next;
    logic write_reg, write_next;
    logic [15:0] wdata_reg, wdata_next;
    logic [15:0] rdata_mem_reg, rdata_mem_next;
    logic done_reg, done_next;
    logic miss_reg, miss_next;
    logic ready_seen, do_write, hit0, hit1;
    memctl_pkg::bank_cfg_type cfg0, cfg1, cfg_sel;
    // struct fields sit in the same order as config bits 14..2
    function automatic memctl_pkg::bank_cfg_type unpack_cfg(input logic [15:0] r);
        unpack_cfg = memctl_pkg::bank_cfg_type'(r[memctl_pkg::LEN_MSB:memctl_pkg::WAIT_LSB]);
    endfunction : unpack_cfg
    // region check with one extra address bit so the end never wraps
    function automatic logic in_region(input logic [22:0] a, input logic [22:0] start,
                                       input logic [6:0] len);
        logic [23:0] stop;
        // length plus one needs eight bits: 7f must give 8 MB, not zero
        stop = {1'b0, start} + {{1'b0, len} + 8'h01, 16'h0000}; // RULE15
        in_region = ({1'b0, a} >= {1'b0, start}) && ({1'b0, a} < stop); // RULE17
    endfunction : in_region
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] s, input logic [15:0] wmask);
        logic [15:0] bytes;
        bytes = {{8{s[1]}}, {8{s[0]}}} & wmask;
        merge = (old & ~bytes) | (d & bytes);
    endfunction : merge
    ready_sampler ready_path (.clk(CLK), .rst_b(RST_B), .ready_pin(EXT_READY),
        .sync_on(cfg_sel.ready_sync_option), .ready_seen(ready_seen));
    assign cfg0 = unpack_cfg(bank0_config_reg);
    assign cfg1 = unpack_cfg(bank1_config_reg);
    assign cfg_sel = sel1_reg ? cfg1 : cfg0;
    assign hit0 = cfg0.bank_on && in_region(MEM_REQ.addr, 23'h000000, cfg0.len); // RULE16 RULE18
    assign hit1 = cfg1.bank_on && in_region(MEM_REQ.addr,
        {bank1_start_reg[memctl_pkg::START_MSB:0], 11'h000}, cfg1.len); // RULE1
    // bus slave
    assign AWREADY = !aw_held_reg && !bvalid_reg;
    assign WREADY = !w_held_reg && !bvalid_reg;
    assign ARREADY = !rvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        aw_addr_next = aw_addr_reg;
        aw_bad_next = aw_bad_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        bank0_config_next = bank0_config_reg;
        bank1_config_next = bank1_config_reg;
        bank1_start_next = bank1_start_reg;
        if (AWVALID && AWREADY) begin
            aw_held_next = 1'b1;
            aw_addr_next = AWADDR[4:0];
            aw_bad_next = (AWADDR[31:5] != 27'h0) || (AWADDR[1:0] != 2'b00)
                || (AWADDR[4:0] > memctl_pkg::OFS_BANK1_START);
        end
        if (WVALID && WREADY) begin
            w_held_next = 1'b1;
            w_data_next = WDATA[15:0];
            w_strb_next = WSTRB[1:0];
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = aw_bad_reg ? memctl_pkg::RESP_SLVERR : memctl_pkg::RESP_OKAY;
            if (!aw_bad_reg) begin
                case (aw_addr_reg)
                    memctl_pkg::OFS_BANK0_CONFIG: begin
                        bank0_config_next = merge(bank0_config_reg, w_data_reg, w_strb_reg,
                            memctl_pkg::CONFIG_WMASK);
                    end
                    memctl_pkg::OFS_BANK1_CONFIG: begin
                        bank1_config_next = merge(bank1_config_reg, w_data_reg, w_strb_reg,
                            memctl_pkg::CONFIG_WMASK);
                    end
                    // reserved slots keep their fixed value whatever is written
                    memctl_pkg::OFS_BANK1_START: begin
                        bank1_start_next = merge(bank1_start_reg, w_data_reg, w_strb_reg,
                            memctl_pkg::START_WMASK);
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (bvalid_reg && BREADY) begin
            bvalid_next = 1'b0;
        end
        if (ARVALID && ARREADY) begin
            rvalid_next = 1'b1;
            rresp_next = memctl_pkg::RESP_OKAY;
            rdata_next = 32'h00000000;
            if (ARADDR[31:5] != 27'h0 || ARADDR[1:0] != 2'b00) begin
                rresp_next = memctl_pkg::RESP_SLVERR;
            end else begin
                case (ARADDR[4:0])
                    memctl_pkg::OFS_BANK0_CONFIG: rdata_next = {16'h0000, bank0_config_reg};
                    memctl_pkg::OFS_BANK1_CONFIG: rdata_next = {16'h0000, bank1_config_reg};
                    memctl_pkg::OFS_RESERVED_A: rdata_next = 32'(memctl_pkg::RESERVED_RESET);
                    memctl_pkg::OFS_RESERVED_B: rdata_next = 32'(memctl_pkg::RESERVED_RESET);
                    memctl_pkg::OFS_BANK1_START: rdata_next = {16'h0000, bank1_start_reg};
                    default: rresp_next = memctl_pkg::RESP_SLVERR;
                endcase
            end
        end else if (rvalid_reg && RREADY) begin
            rvalid_next = 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bank0_config_reg <= memctl_pkg::BANK0_CONFIG_RESET; // RULE4
            bank1_config_reg <= memctl_pkg::BANK1_CONFIG_RESET; // RULE5
            bank1_start_reg <= memctl_pkg::BANK1_START_RESET;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            aw_bad_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            bank0_config_reg <= bank0_config_next;
            bank1_config_reg <= bank1_config_next;
            bank1_start_reg <= bank1_start_next;
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            aw_addr_reg <= aw_addr_next;
            aw_bad_reg <= aw_bad_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign RVALID = rvalid_reg;
    assign RRESP = rresp_reg;
    assign RDATA = rdata_reg;
    // memory access sequencer
    assign MEM_REQ_READY = (state_reg == ST_IDLE);
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        sel0_next = sel0_reg;
        sel1_next = sel1_reg;
        ext_on_next = ext_on_reg;
        addr_next = addr_reg;
        write_next = write_reg;
        wdata_next = wdata_reg;
        rdata_mem_next = rdata_mem_reg;
        done_next = 1'b0;
        miss_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (MEM_REQ_VALID) begin
                    if (hit0 || hit1) begin
                        sel0_next = hit0; // RULE12
                        sel1_next = hit1 && !hit0; // RULE12
                        ext_on_next = hit0 ? cfg0.ready_extension_on : cfg1.ready_extension_on;
                        // first count covers waits plus one, last clock ends the select
                        count_next = {1'b0, hit0 ? cfg0.waits : cfg1.waits}
                            + memctl_pkg::BASE_CYCLES - 4'h1; // RULE14
                        addr_next = MEM_REQ.addr;
                        write_next = MEM_REQ.write;
                        wdata_next = MEM_REQ.wdata;
                        state_next = ST_WAIT;
                    end else begin
                        miss_next = 1'b1; // RULE16
                    end
                end
            end
            ST_WAIT: begin
                count_next = count_reg - 4'h1;
                if (count_reg == 4'h1) begin
                    state_next = ST_READY; // RULE7 RULE8
                end
            end
            ST_READY: begin
                // last clock of the select; with ready extension on, stretched while ready reads low
                if (!ext_on_reg || ready_seen) begin // RULE7 RULE8
                    rdata_mem_next = EXT_DATA_IN;
                    sel0_next = 1'b0;
                    sel1_next = 1'b0;
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                sel0_next = 1'b0;
                sel1_next = 1'b0;
            end
        endcase
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= ST_IDLE;
            count_reg <= 4'h0;
            sel0_reg <= 1'b0;
            sel1_reg <= 1'b0;
            ext_on_reg <= 1'b0;
            addr_reg <= 23'h000000;
            write_reg <= 1'b0;
            wdata_reg <= 16'h0000;
            rdata_mem_reg <= 16'h0000;
            done_reg <= 1'b0;
            miss_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            sel0_reg <= sel0_next;
            sel1_reg <= sel1_next;
            ext_on_reg <= ext_on_next;
            addr_reg <= addr_next;
            write_reg <= write_next;
            wdata_reg <= wdata_next;
            rdata_mem_reg <= rdata_mem_next;
            done_reg <= done_next;
            miss_reg <= miss_next;
        end
    end
    assign SELECT_LINE_PRIMARY_B = !sel0_reg;
    assign SELECT_LINE_SECONDARY_B = !sel1_reg;
    assign EXT_ADDR = addr_reg;
    assign EXT_DATA_OUT = wdata_reg;
    assign EXT_DATA_OE_B = !((sel0_reg || sel1_reg) && write_reg);
    assign EXT_WRITE_B = !((sel0_reg || sel1_reg) && write_reg);
    assign EXT_READ_B = !((sel0_reg || sel1_reg) && !write_reg);
    assign MEM_RDATA = rdata_mem_reg;
    assign MEM_DONE = done_reg;
    assign MEM_MISS = miss_reg;
    assign ACCESS_BUSY = (state_reg != ST_IDLE);
endmodule : external_memory_bank_controller

//--- tb/ext_memory_model.sv
`timescale 1ns/1ns
// far-side static memory; ready follows a programmable stall after the select falls
module ext_memory_model (
    // clock
    input wire logic clk,
    // memory pins
    input wire logic select_b,
    input wire logic [22:0] addr,
    input wire logic [15:0] data_out,
    input wire logic write_b,
    input wire logic read_b,
    output logic [15:0] data_in,
    output logic ready,
    // stall length in cycles
    input wire logic [3:0] slow
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0;
    logic [3:0] cnt = 4'h0;
    logic toggle = 1'b0;

    always @(posedge clk) begin
        if (select_b) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
        toggle <= ~toggle;
        if (!select_b && !write_b) mem[addr[7:0]] <= data_out;
        if (!read_b) last <= data_in;
    end
    // a released bus shows the inverse of its last value, never a held copy
    assign data_in = (!select_b && !read_b) ? mem[addr[7:0]] : ~last;
    // ready wanders outside selects so a design that samples it early is caught
    assign ready = select_b ? toggle : (cnt >= slow);
endmodule : ext_memory_model

//--- tb/memctl_assertions.sv
`timescale 1ns/1ns
module memctl_assertions (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // request side
    input wire logic MEM_REQ_VALID,
    input wire logic MEM_REQ_READY,
    input wire logic MEM_DONE,
    input wire logic MEM_MISS,
    // external memory port
    input wire logic [22:0] EXT_ADDR,
    input wire logic EXT_DATA_OE_B,
    input wire logic EXT_WRITE_B,
    input wire logic EXT_READ_B,
    input wire logic SELECT_LINE_PRIMARY_B,
    input wire logic SELECT_LINE_SECONDARY_B
);
    logic any_sel;
    assign any_sel = !(SELECT_LINE_PRIMARY_B && SELECT_LINE_SECONDARY_B);

    default clocking main_clk @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    a_one_select: assert property (SELECT_LINE_PRIMARY_B || SELECT_LINE_SECONDARY_B)
        else $error("two selects active");
    a_select_min: assert property ($rose(any_sel) |=> any_sel)
        else $error("select shorter than two cycles");
    a_done_follows: assert property ($fell(any_sel) |-> MEM_DONE)
        else $error("no done after select");
    a_done_pulse: assert property (MEM_DONE |=> !MEM_DONE)
        else $error("done longer than one cycle");
    a_miss_quiet: assert property (MEM_MISS |-> (!any_sel) [*2])
        else $error("select during a miss");
    a_take_answer: assert property (MEM_REQ_VALID && MEM_REQ_READY
        |-> ##[1:2] (any_sel || MEM_MISS)) else $error("request left unanswered");
    a_strobe_inside: assert property (!(EXT_READ_B && EXT_WRITE_B) |-> any_sel)
        else $error("strobe outside select");
    a_addr_steady: assert property (any_sel && $past(any_sel) |-> $stable(EXT_ADDR))
        else $error("address moved during select");
    a_write_drives: assert property (!EXT_WRITE_B |-> !EXT_DATA_OE_B)
        else $error("write strobe without data drive");

    c_primary: cover property ($fell(SELECT_LINE_PRIMARY_B));
    c_secondary: cover property ($fell(SELECT_LINE_SECONDARY_B));
    c_miss: cover property (MEM_MISS);
endmodule : memctl_assertions

bind external_memory_bank_controller memctl_assertions memctl_assertions_inst (
    .CLK(CLK), .RST_B(RST_B), .MEM_REQ_VALID(MEM_REQ_VALID), .MEM_REQ_READY(MEM_REQ_READY),
    .MEM_DONE(MEM_DONE), .MEM_MISS(MEM_MISS), .EXT_ADDR(EXT_ADDR),
    .EXT_DATA_OE_B(EXT_DATA_OE_B), .EXT_WRITE_B(EXT_WRITE_B), .EXT_READ_B(EXT_READ_B),
    .SELECT_LINE_PRIMARY_B(SELECT_LINE_PRIMARY_B),
    .SELECT_LINE_SECONDARY_B(SELECT_LINE_SECONDARY_B));

//--- tb/external_memory_bank_controller_test.sv
`timescale 1ns/1ns
module external_memory_bank_controller_test;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0, RDATA;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic MEM_REQ_VALID = 1'b0;
    memctl_pkg::mem_req_type MEM_REQ = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_REQ_READY, MEM_DONE, MEM_MISS;
    logic [1:0] BRESP, RRESP;
    logic [15:0] MEM_RDATA, EXT_DATA_OUT, EXT_DATA_IN;
    logic [22:0] EXT_ADDR;
    logic EXT_DATA_OE_B, EXT_WRITE_B, EXT_READ_B, SEL0_B, SEL1_B, EXT_READY, BUSY;
    logic [3:0] slow = 4'h0;
    logic [31:0] seed = 32'h9b292531;
    logic [15:0] shadow [0:255];
    logic [15:0] rv [5] = '{16'h7f3d, 16'h0001, 16'h0001, 16'h0001, 16'h0000};
    logic [7:0] rlen [4] = '{8'h07, 8'h07, 8'h0b, 8'h0d};
    logic [1:0] bq[$];
    logic [33:0] rq[$], mq[$], note;
    logic [7:0] pc = 8'h0, sc = 8'h0;
    int errors = 0, n_tests = 0;

    always #25 CLK = ~CLK;

    external_memory_bank_controller external_memory_bank_controller_inst (
        .CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .MEM_REQ(MEM_REQ), .MEM_REQ_VALID(MEM_REQ_VALID), .MEM_REQ_READY(MEM_REQ_READY),
        .MEM_RDATA(MEM_RDATA), .MEM_DONE(MEM_DONE), .MEM_MISS(MEM_MISS),
        .EXT_ADDR(EXT_ADDR), .EXT_DATA_OUT(EXT_DATA_OUT), .EXT_DATA_IN(EXT_DATA_IN),
        .EXT_DATA_OE_B(EXT_DATA_OE_B), .EXT_WRITE_B(EXT_WRITE_B), .EXT_READ_B(EXT_READ_B),
        .SELECT_LINE_PRIMARY_B(SEL0_B), .SELECT_LINE_SECONDARY_B(SEL1_B),
        .EXT_READY(EXT_READY), .ACCESS_BUSY(BUSY));

    // both banks share one memory device, so its select is the and of the two
    ext_memory_model ext_memory_model_inst (.clk(CLK), .select_b(SEL0_B & SEL1_B),
        .addr(EXT_ADDR), .data_out(EXT_DATA_OUT), .write_b(EXT_WRITE_B), .read_b(EXT_READ_B),
        .data_in(EXT_DATA_IN), .ready(EXT_READY), .slow(slow));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // config word: bit 0 always written one, reserved bits zero
    function automatic logic [31:0] cfg(input logic [6:0] ln, input logic re, input logic sy,
                                        input logic on, input logic [2:0] w);
        return {16'h0, 1'b0, ln, re, sy, on, w, 2'b01};
    endfunction : cfg

    task automatic check(input logic [33:0] e, input logic [33:0] g);
        n_tests++;
        if (e !== g) begin
            errors++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : check

    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] r = memctl_pkg::RESP_OKAY);
        bq.push_back(r);
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (!BVALID);
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] r = memctl_pkg::RESP_OKAY);
        rq.push_back({r, d});
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (!RVALID);
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask : axi_rd

    // bank 0 means no bank is hit; len is the expected select length in cycles
    task automatic mem(input logic [22:0] a, input logic wr, input logic [1:0] bank,
                       input logic [7:0] len);
        logic [15:0] d;
        d = 16'(rnd() >> 16);
        if (wr && bank != 2'd0) shadow[a[7:0]] = d;
        mq.push_back({!wr && bank != 2'd0, bank == 2'd0, (bank == 2'd1) ? len : 8'h0,
                      (bank == 2'd2) ? len : 8'h0,
                      (!wr && bank != 2'd0) ? shadow[a[7:0]] : 16'h0});
        MEM_REQ <= '{addr: a, write: wr, wdata: d};
        MEM_REQ_VALID <= 1'b1;
        do @(posedge CLK); while (!MEM_REQ_READY);
        MEM_REQ_VALID <= 1'b0;
        do @(posedge CLK); while (!(MEM_DONE || MEM_MISS));
        @(posedge CLK);
    endtask : mem

    task automatic rw(input logic [22:0] a, input logic [1:0] bank, input logic [7:0] len);
        mem(a, 1'b1, bank, len);
        mem(a, 1'b0, bank, len);
    endtask : rw

    always @(posedge CLK) begin
        if (BVALID && BREADY) check({32'h0, bq.pop_front()}, {32'h0, BRESP});
        if (RVALID && RREADY) begin
            note = rq.pop_front();
            check(note, {RRESP, (note[33:32] === memctl_pkg::RESP_OKAY) ? RDATA : 32'h0});
        end
        if (!SEL0_B) pc++;
        if (!SEL1_B) sc++;
        if (MEM_DONE || MEM_MISS) begin
            note = mq.pop_front();
            check({1'b0, note[32:0]}, {BUSY, MEM_MISS, pc, sc, note[33] ? MEM_RDATA : 16'h0});
            pc = 8'h0;
            sc = 8'h0;
        end
    end

    initial begin
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        foreach (rv[i]) axi_rd(32'(i * 4), {16'h0, rv[i]});
        axi_rd(32'h14, 32'h0, memctl_pkg::RESP_SLVERR);
        axi_wr(32'h14, 32'h1, memctl_pkg::RESP_SLVERR);
        axi_wr(32'h8, 32'h1);
        rw(23'h000010, 2'd1, 8'h09);
        for (int w = 0; w < 8; w++) begin
            axi_wr(32'h0, cfg(7'h0, 1'b0, 1'b0, 1'b1, 3'(w)));
            rw(23'(rnd() & 32'hfffe), 2'd1, 8'(w + 2));
        end
        axi_rd(32'h0, cfg(7'h0, 1'b0, 1'b0, 1'b1, 3'h7));
        axi_wr(32'h4, cfg(7'h0, 1'b0, 1'b0, 1'b1, 3'h3));
        axi_wr(32'h10, 32'h020);
        axi_rd(32'h10, 32'h020);
        rw(23'h010000, 2'd2, 8'h05);
        rw(23'h01fffe, 2'd2, 8'h05);
        mem(23'h020000, 1'b0, 2'd0, 8'h0);
        rw(23'h00fffe, 2'd1, 8'h09);
        axi_wr(32'h10, 32'h021);
        mem(23'h0107fe, 1'b1, 2'd0, 8'h0);
        rw(23'h010800, 2'd2, 8'h05);
        axi_wr(32'h10, 32'h001);
        rw(23'h000800, 2'd1, 8'h09);
        axi_wr(32'h0, cfg(7'h0, 1'b0, 1'b0, 1'b0, 3'h7));
        rw(23'h000800, 2'd2, 8'h05);
        mem(23'h000000, 1'b0, 2'd0, 8'h0);
        // five waits keeps the unsynchronised ready legal
        for (int i = 0; i < 4; i++) begin
            axi_wr(32'h0, cfg(7'h0, i > 0, i == 3, 1'b1, 3'h5));
            slow <= (i == 1) ? 4'h0 : 4'h8;
            rw(23'h000040, 2'd1, rlen[i]);
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        errors++;
        report_and_stop();
    end
endmodule : external_memory_bank_controller_test
